/* File: uimr_pkg.sv */
// Package: register map, field positions and reset values of the USB interface manager.
package uimr_pkg;
	// =====================================================================
	// Register offsets (byte addresses of 32-bit words)
	localparam logic [7:0] OFF_IM_RESET = 8'h00;
	localparam logic [7:0] OFF_DEV_ADDR = 8'h08;
	localparam logic [7:0] OFF_FUNC_CTL = 8'h0c;
	localparam logic [7:0] OFF_OTG_CTL = 8'h10;
	localparam logic [7:0] OFF_OTG_STAT = 8'h14;
	localparam logic [7:0] OFF_SER_CTL = 8'h18;
	localparam logic [7:0] OFF_EVT_FLAGS = 8'h1c;
	localparam logic [7:0] OFF_HOLD_SEL = 8'h20;
	localparam logic [7:0] OFF_PORT_MASKS = 8'h24;
	localparam logic [7:0] OFF_FRAME_CNT = 8'h28;
	localparam logic [7:0] OFF_LAST_PID = 8'h2c;
	localparam logic [7:0] OFF_LAST_EP = 8'h30;
	localparam logic [7:0] OFF_EP_MARK = 8'h34;
	localparam logic [7:0] OFF_OTG_MASK = 8'h38;
	localparam logic [7:0] OFF_PWR_SIG = 8'h3c;
	localparam logic [7:0] OFF_XCVR_CTL = 8'h40;

	// =====================================================================
	// Reset values
	localparam logic [4:0] RST_FUNC_CTL = 5'h07;
	localparam logic [6:0] RST_SER_CTL = 7'h02;

	// =====================================================================
	// Field positions
	localparam int FC_OPMODE_LSB = 2;
	localparam int SC_TXEN_N = 1;
	localparam int SC_TXSE0 = 3;
	localparam int SC_TXDAT = 2;
	localparam int SC_FSLS = 0;
	localparam int FL_TOKEN = 6;
	localparam int FL_SE0 = 5;
	localparam int FL_K = 4;
	localparam int FL_J = 3;
	localparam int FL_CRC16 = 2;
	localparam int FL_RXACT = 1;
	localparam int FL_RXERR = 0;
	localparam int EP_VALID = 4;
	localparam int XC_PD_OFF = 18;
	localparam int XC_WAKE_SE0 = 13;
	localparam int XC_WAKE_K = 12;
	localparam int XC_FILT_LSB = 8;
	localparam int XC_AUTO_RES = 7;
	localparam int XC_CONF_LSB = 4;
	localparam int PS_VALID = 8;

	// =====================================================================
	// Line states and token codes
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_J = 2'h1;
	localparam logic [1:0] LS_K = 2'h2;
	localparam logic [3:0] PID_SOF = 4'h5;
	localparam logic [4:0] EP_MARK_OR = 5'h10;
endpackage : uimr_pkg

/* File: uimr_regs.sv */
// USB interface manager control and status registers with flag, filter and endpoint logic.
module uimr_regs (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Register access
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// Transceiver status inputs
	input wire logic [1:0] i_linestate,
	input wire logic i_rx_active,
	input wire logic i_rx_error,
	input wire logic i_rx_rcv,
	input wire logic i_rx_dm,
	input wire logic i_rx_dp,
	input wire logic [5:0] i_otg_status,
	// Token decoder results
	input wire logic i_tok_ok,
	input wire logic [3:0] i_tok_pid,
	input wire logic [6:0] i_tok_addr,
	input wire logic [3:0] i_tok_ep,
	input wire logic [10:0] i_tok_frame,
	input wire logic i_crc16_fail,
	input wire logic i_pkt_start,
	input wire logic i_auto_resume,
	// Transceiver controls
	output logic [2:0] o_opmode,
	output logic o_termselect,
	output logic o_xcvrselect,
	output logic [7:0] o_otg_ctl,
	output logic o_tx_se0,
	output logic o_tx_dat,
	output logic o_tx_enable_n,
	output logic o_fsls_serial,
	output logic o_line_port_low_pd_en,
	output logic o_line_port_high_pd_en,
	output logic [2:0] o_transceiver_config_inputs,
	output logic [8:0] o_power_sig,
	// Event ports and forwarded tokens
	output logic o_event_port_a,
	output logic o_event_port_b,
	output logic o_event_port_c,
	output logic o_event_port_d,
	output logic o_tok_fwd,
	output logic [4:0] o_rx_ep,
	output logic [1:0] o_linestate_filt
);

	// =====================================================================
	// Decode helpers
	function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
		wr_hit = wr && (a == off);
	endfunction

	logic soft_rst;
	logic clr_all;
	logic clr_mgr;
	// Reset register write restores manager state; transceiver-facing controls stay put
	assign soft_rst = wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_IM_RESET);
	assign clr_all = !i_rst_n;
	assign clr_mgr = !i_rst_n || soft_rst;

	// =====================================================================
	// Transceiver-facing control registers (not touched by the soft reset)
	logic [4:0] func_ff, nxt_func;
	logic [7:0] otg_ff, nxt_otg;
	logic [3:0] ser_ff, nxt_ser;
	logic [3:0] xc_lo_ff, nxt_xc_lo;
	logic [3:0] filt_log_ff, nxt_filt_log;
	logic pd_off_ff, nxt_pd_off;
	logic wake_se0_ff, nxt_wake_se0;
	logic wake_k_ff, nxt_wake_k;
	logic [1:0] filt_ff;
	logic wake_go;

	// Auto-resume is honoured only when its enable bit is set
	assign wake_go = i_auto_resume && xc_lo_ff[uimr_pkg::XC_AUTO_RES - uimr_pkg::XC_CONF_LSB];

	// Next values for control registers; wake bits favour hardware set over clear
	always_comb begin
		nxt_func = func_ff;
		nxt_otg = otg_ff;
		nxt_ser = ser_ff;
		nxt_xc_lo = xc_lo_ff;
		nxt_filt_log = filt_log_ff;
		nxt_pd_off = pd_off_ff;
		nxt_wake_se0 = wake_se0_ff;
		nxt_wake_k = wake_k_ff;
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_FUNC_CTL)) begin
			nxt_func = i_reg_wdata[4:0];
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_OTG_CTL)) begin
			nxt_otg = i_reg_wdata[7:0] & 8'hdf;
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_SER_CTL)) begin
			nxt_ser = i_reg_wdata[3:0];
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_XCVR_CTL)) begin
			nxt_pd_off = i_reg_wdata[uimr_pkg::XC_PD_OFF];
			nxt_filt_log = i_reg_wdata[11:8];
			nxt_xc_lo = i_reg_wdata[7:4];
			// Writing 0 clears; writing 1 leaves the bit as it was
			nxt_wake_se0 = wake_se0_ff && i_reg_wdata[uimr_pkg::XC_WAKE_SE0];
			nxt_wake_k = wake_k_ff && i_reg_wdata[uimr_pkg::XC_WAKE_K];
		end
		if (wake_go && filt_ff == uimr_pkg::LS_SE0) begin
			nxt_wake_se0 = 1'b1;
		end
		if (wake_go && filt_ff == uimr_pkg::LS_K) begin
			nxt_wake_k = 1'b1;
		end
	end

	// Control registers follow the pin reset only
	always_ff @(posedge i_mclk) begin
		if (clr_all) begin
			func_ff <= uimr_pkg::RST_FUNC_CTL;
			otg_ff <= 8'h00;
			ser_ff <= uimr_pkg::RST_SER_CTL[3:0];
			xc_lo_ff <= 4'h0;
			filt_log_ff <= 4'h0;
			pd_off_ff <= 1'b0;
			wake_se0_ff <= 1'b0;
			wake_k_ff <= 1'b0;
		end else begin
			func_ff <= nxt_func;
			otg_ff <= nxt_otg;
			ser_ff <= nxt_ser;
			xc_lo_ff <= nxt_xc_lo;
			filt_log_ff <= nxt_filt_log;
			pd_off_ff <= nxt_pd_off;
			wake_se0_ff <= nxt_wake_se0;
			wake_k_ff <= nxt_wake_k;
		end
	end

	assign o_opmode = func_ff[4:2];
	assign o_termselect = func_ff[1];
	assign o_xcvrselect = func_ff[0];
	assign o_otg_ctl = otg_ff;
	assign o_tx_se0 = ser_ff[uimr_pkg::SC_TXSE0];
	assign o_tx_dat = ser_ff[uimr_pkg::SC_TXDAT];
	assign o_tx_enable_n = ser_ff[uimr_pkg::SC_TXEN_N];
	assign o_fsls_serial = ser_ff[uimr_pkg::SC_FSLS];
	assign o_line_port_low_pd_en = !pd_off_ff;
	assign o_line_port_high_pd_en = !pd_off_ff;
	assign o_transceiver_config_inputs = xc_lo_ff[2:0];

	// =====================================================================
	// Line-state filter: a new state must stand 2^N clocks before it passes
	logic [1:0] cand_ff, nxt_cand, nxt_filt;
	logic [15:0] cnt_ff, nxt_cnt;
	logic [15:0] filt_len;

	assign filt_len = 16'(16'h0001 << filt_log_ff) - 16'h0001;

	// Counter restarts on every input change, so glitches never reach the flags
	always_comb begin
		nxt_cand = cand_ff;
		nxt_cnt = cnt_ff;
		nxt_filt = filt_ff;
		if (i_linestate != cand_ff) begin
			nxt_cand = i_linestate;
			nxt_cnt = 16'h0000;
		end else if (cnt_ff >= filt_len) begin
			nxt_filt = cand_ff;
		end else begin
			nxt_cnt = cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (clr_mgr) begin
			cand_ff <= uimr_pkg::LS_SE0;
			cnt_ff <= 16'h0000;
			filt_ff <= uimr_pkg::LS_SE0;
		end else begin
			cand_ff <= nxt_cand;
			cnt_ff <= nxt_cnt;
			filt_ff <= nxt_filt;
		end
	end

	assign o_linestate_filt = filt_ff;

	// =====================================================================
	// Manager state: address, flags, masks, captures, marks, power value
	logic [6:0] addr_ff, nxt_addr;
	logic [6:0] flags_ff, nxt_flags;
	logic [6:0] hold_ff, nxt_hold;
	logic [31:0] masks_ff, nxt_masks;
	logic [10:0] frame_ff, nxt_frame;
	logic [3:0] pid_ff, nxt_pid;
	logic [4:0] ep_ff, nxt_ep;
	logic [15:0] mark_ff, nxt_mark;
	logic [31:0] omask_ff, nxt_omask;
	logic [8:0] pwr_ff, nxt_pwr;
	logic [6:0] flag_set;
	logic [6:0] flag_w1c;
	logic tok_match;
	logic tok_sof;

	assign tok_sof = i_tok_ok && (i_tok_pid == uimr_pkg::PID_SOF);
	assign tok_match = i_tok_ok && !tok_sof && (i_tok_addr == addr_ff);

	// Sources that raise each flag this cycle
	always_comb begin
		flag_set = 7'h00;
		flag_set[uimr_pkg::FL_TOKEN] = tok_match;
		flag_set[uimr_pkg::FL_SE0] = (filt_ff == uimr_pkg::LS_SE0);
		flag_set[uimr_pkg::FL_K] = (filt_ff == uimr_pkg::LS_K);
		flag_set[uimr_pkg::FL_J] = (filt_ff == uimr_pkg::LS_J);
		flag_set[uimr_pkg::FL_CRC16] = i_crc16_fail;
		flag_set[uimr_pkg::FL_RXACT] = i_rx_active;
		flag_set[uimr_pkg::FL_RXERR] = i_rx_error;
		flag_w1c = 7'h00;
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_EVT_FLAGS)) begin
			flag_w1c = i_reg_wdata[6:0];
		end
	end

	// Next values of manager state; hardware capture wins over software writes
	always_comb begin
		nxt_addr = addr_ff;
		nxt_hold = hold_ff;
		nxt_masks = masks_ff;
		nxt_frame = frame_ff;
		nxt_pid = pid_ff;
		nxt_ep = ep_ff;
		nxt_mark = mark_ff;
		nxt_omask = omask_ff;
		nxt_pwr = pwr_ff;
		for (int b = 0; b < 7; b++) begin
			if (hold_ff[b]) begin
				// Held flag: keep until a 1 is written, a new set still wins
				nxt_flags[b] = (flags_ff[b] && !flag_w1c[b]) || flag_set[b];
			end else if (b <= uimr_pkg::FL_RXACT) begin
				nxt_flags[b] = flag_set[b];
			end else begin
				nxt_flags[b] = (flags_ff[b] && !i_pkt_start && !flag_w1c[b]) || flag_set[b];
			end
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_DEV_ADDR)) begin
			nxt_addr = i_reg_wdata[6:0];
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_HOLD_SEL)) begin
			nxt_hold = i_reg_wdata[6:0];
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_PORT_MASKS)) begin
			nxt_masks = i_reg_wdata;
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_FRAME_CNT)) begin
			nxt_frame = i_reg_wdata[10:0];
		end
		if (tok_sof) begin
			nxt_frame = i_tok_frame;
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_EP_MARK)) begin
			nxt_mark = i_reg_wdata[15:0];
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_OTG_MASK)) begin
			nxt_omask = i_reg_wdata;
		end
		if (wr_hit(i_reg_wr, i_reg_addr, uimr_pkg::OFF_PWR_SIG)) begin
			nxt_pwr = i_reg_wdata[8:0];
		end
		if (tok_match) begin
			nxt_pid = i_tok_pid;
			nxt_ep = {1'b1, i_tok_ep};
		end
	end

	always_ff @(posedge i_mclk) begin
		if (clr_mgr) begin
			addr_ff <= 7'h00;
			flags_ff <= 7'h00;
			hold_ff <= 7'h00;
			masks_ff <= 32'h0000_0000;
			frame_ff <= 11'h000;
			pid_ff <= 4'h0;
			ep_ff <= 5'h00;
			mark_ff <= 16'h0000;
			omask_ff <= 32'h0000_0000;
			pwr_ff <= 9'h000;
		end else begin
			addr_ff <= nxt_addr;
			flags_ff <= nxt_flags;
			hold_ff <= nxt_hold;
			masks_ff <= nxt_masks;
			frame_ff <= nxt_frame;
			pid_ff <= nxt_pid;
			ep_ff <= nxt_ep;
			mark_ff <= nxt_mark;
			omask_ff <= nxt_omask;
			pwr_ff <= nxt_pwr;
		end
	end

	assign o_power_sig = pwr_ff;

	// =====================================================================
	// Registered outputs: event ports, forwarded token, status sampling, readback
	logic [3:0] evt_ff, nxt_evt;
	logic fwd_ff;
	logic [4:0] rx_ep_ff, nxt_rx_ep;
	logic [5:0] otg_st_ff;
	logic [2:0] ser_st_ff;
	logic [31:0] rdata_ff, nxt_rdata;
	logic rvalid_ff;

	// Ports look at the flags as stored, one cycle behind the flag register
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			nxt_evt[p] = |(flags_ff & masks_ff[p*8 +: 7]);
		end
		nxt_rx_ep = rx_ep_ff;
		if (tok_match) begin
			nxt_rx_ep = {1'b0, i_tok_ep} | (mark_ff[i_tok_ep] ? uimr_pkg::EP_MARK_OR : 5'h00);
		end
		nxt_rdata = 32'h0000_0000;
		case (i_reg_addr)
			uimr_pkg::OFF_DEV_ADDR: nxt_rdata = {25'h0, addr_ff};
			uimr_pkg::OFF_FUNC_CTL: nxt_rdata = {27'h0, func_ff};
			uimr_pkg::OFF_OTG_CTL: nxt_rdata = {24'h0, otg_ff};
			uimr_pkg::OFF_OTG_STAT: nxt_rdata = {26'h0, otg_st_ff};
			uimr_pkg::OFF_SER_CTL: nxt_rdata = {25'h0, ser_st_ff, ser_ff};
			uimr_pkg::OFF_EVT_FLAGS: nxt_rdata = {25'h0, flags_ff};
			uimr_pkg::OFF_HOLD_SEL: nxt_rdata = {25'h0, hold_ff};
			uimr_pkg::OFF_PORT_MASKS: nxt_rdata = masks_ff;
			uimr_pkg::OFF_FRAME_CNT: nxt_rdata = {21'h0, frame_ff};
			uimr_pkg::OFF_LAST_PID: nxt_rdata = {28'h0, pid_ff};
			uimr_pkg::OFF_LAST_EP: nxt_rdata = {27'h0, ep_ff};
			uimr_pkg::OFF_EP_MARK: nxt_rdata = {16'h0, mark_ff};
			uimr_pkg::OFF_OTG_MASK: nxt_rdata = omask_ff;
			uimr_pkg::OFF_PWR_SIG: nxt_rdata = {23'h0, pwr_ff};
			uimr_pkg::OFF_XCVR_CTL: nxt_rdata = {13'h0, pd_off_ff, 4'h0, wake_se0_ff,
				wake_k_ff, filt_log_ff, xc_lo_ff, 4'h0};
			default: nxt_rdata = 32'h0000_0000;
		endcase
		if (!i_reg_rd) begin
			nxt_rdata = rdata_ff;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (clr_mgr) begin
			evt_ff <= 4'h0;
			fwd_ff <= 1'b0;
			rx_ep_ff <= 5'h00;
			otg_st_ff <= 6'h00;
			ser_st_ff <= 3'h0;
			rdata_ff <= 32'h0000_0000;
			rvalid_ff <= 1'b0;
		end else begin
			evt_ff <= nxt_evt;
			fwd_ff <= tok_match;
			rx_ep_ff <= nxt_rx_ep;
			otg_st_ff <= i_otg_status;
			ser_st_ff <= {i_rx_rcv, i_rx_dm, i_rx_dp};
			rdata_ff <= nxt_rdata;
			rvalid_ff <= i_reg_rd;
		end
	end

	assign o_event_port_a = evt_ff[0];
	assign o_event_port_b = evt_ff[1];
	assign o_event_port_c = evt_ff[2];
	assign o_event_port_d = evt_ff[3];
	assign o_tok_fwd = fwd_ff;
	assign o_rx_ep = rx_ep_ff;
	assign o_reg_rdata = rdata_ff;
	assign o_reg_rvalid = rvalid_ff;

	// =====================================================================
	// Assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	sequence good_tok_s;
		i_tok_ok && !tok_sof && i_tok_addr == addr_ff && !soft_rst;
	endsequence

	func_reset_a: assert property ($rose(i_rst_n) |-> o_opmode == 3'h1 && o_termselect)
		else $error("functional control not at reset value");
	txen_reset_a: assert property ($rose(i_rst_n) |-> o_tx_enable_n)
		else $error("transmit enable not off after reset");
	token_flag_a: assert property (
		good_tok_s |=> flags_ff[uimr_pkg::FL_TOKEN] && o_tok_fwd)
		else $error("token flag not set on matching token");
	tok_forward_a: assert property (
		i_tok_ok && i_tok_addr != addr_ff && !soft_rst |=> !o_tok_fwd)
		else $error("token forwarded with wrong address");
	sticky_hold_a: assert property (
		hold_ff[2] && flags_ff[2] && !soft_rst && !flag_w1c[2] |=> flags_ff[2])
		else $error("held flag dropped without write");
	// Port b is one of the lanes the bench exercises, so this antecedent is really reached
	event_port_a: assert property (
		(|(flags_ff & masks_ff[14:8])) && !soft_rst |=> o_event_port_b)
		else $error("event port b low with selected flag high");
	sof_load_a: assert property (tok_sof && !soft_rst |=> frame_ff == $past(i_tok_frame))
		else $error("frame counter not loaded from token");
	ep_mark_a: assert property (
		good_tok_s and mark_ff[i_tok_ep] |=> o_rx_ep[4] && ep_ff[uimr_pkg::EP_VALID])
		else $error("marked endpoint not ORed with 0x10");
	soft_reset_a: assert property (
		soft_rst |=> addr_ff == 7'h00 && flags_ff == 7'h00 && o_termselect == $past(o_termselect))
		else $error("soft reset wrong effect");
	wake_k_a: assert property (wake_go && filt_ff == uimr_pkg::LS_K |=> wake_k_ff)
		else $error("K wake bit not set");

endmodule : uimr_regs // uimr_regs

/* File: uimr_regs_tb.sv */
// Self-checking bench for the interface manager register block.
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module uimr_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_mclk = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, o_reg_rvalid, o_tok_fwd;
	logic [7:0] i_reg_addr = 8'h00, o_otg_ctl;
	logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, r, qe, qm, exp_q[$], msk_q[$];
	logic i_rx_active, i_rx_error, i_rx_rcv, i_rx_dm, i_rx_dp, o_tx_se0, o_tx_dat;
	logic [1:0] i_linestate, o_linestate_filt, host_ls = 2'h1, rx_in = 2'h0;
	logic [5:0] i_otg_status, otg_in = 6'h00;
	logic i_tok_ok = 0, i_crc16_fail = 0, i_pkt_start = 0, i_auto_resume = 0;
	logic [3:0] i_tok_pid = 4'h0, i_tok_ep = 4'h0;
	logic [6:0] i_tok_addr = 7'h00, dadr;
	logic [10:0] i_tok_frame = 11'h000;
	logic [2:0] o_opmode, o_transceiver_config_inputs;
	logic o_termselect, o_xcvrselect, o_tx_enable_n, o_fsls_serial;
	logic o_line_port_low_pd_en, o_line_port_high_pd_en;
	logic o_event_port_a, o_event_port_b, o_event_port_c, o_event_port_d;
	logic [8:0] o_power_sig;
	logic [4:0] o_rx_ep;
	int mismatches = 0, tests_run = 0;
	wire logic [3:0] evp = {o_event_port_d, o_event_port_c, o_event_port_b, o_event_port_a};
	always #12.5 i_mclk = ~i_mclk;
	uimr_regs uut (.*);
	uimr_xcvr_model xcvr (.i_mclk(i_mclk), .i_tx_enable_n(o_tx_enable_n), .i_tx_se0(o_tx_se0),
		.i_tx_dat(o_tx_dat), .i_host_ls(host_ls), .i_rx_in(rx_in), .i_otg_in(otg_in),
		.o_linestate(i_linestate), .o_rx_active(i_rx_active), .o_rx_error(i_rx_error),
		.o_rx_rcv(i_rx_rcv), .o_rx_dm(i_rx_dm), .o_rx_dp(i_rx_dp), .o_otg_status(i_otg_status));
	// =====
	// Bus tasks: inputs move 1 ns after the edge and hold through the sampling edge
	task automatic step();
		@(posedge i_mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		step();
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		step();
		i_reg_wr = 1'b0;
	endtask
	// The expected word is queued; the watcher compares it when rvalid shows
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		step();
		i_reg_rd = 1'b1;
		i_reg_addr = a;
		exp_q.push_back(e);
		msk_q.push_back(m);
		step();
		i_reg_rd = 1'b0;
		step();
	endtask
	task automatic pulse(ref logic s);
		step();
		s = 1'b1;
		step();
		s = 1'b0;
	endtask
	task automatic tok(input logic [6:0] a, input logic [3:0] p, e, input logic [10:0] f);
		step();
		{i_tok_addr, i_tok_pid, i_tok_ep, i_tok_frame} = {a, p, e, f};
		i_tok_ok = 1'b1;
		step();
		i_tok_ok = 1'b0;
	endtask
	// Bounded wait for the filtered line; a timeout ends the run
	task automatic waitls(input logic [1:0] v, input int mn);
		int n;
		n = 0;
		while (o_linestate_filt !== v && n < 40) begin
			step();
			n++;
		end
		`CHK({o_linestate_filt, n >= mn}, {v, 1'b1})
		if (o_linestate_filt !== v) test_done();
	endtask
	task automatic test_done();
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// =====
	// Read watcher: rdata is taken in the cycle rvalid stands
	always @(posedge i_mclk) begin
		if (o_reg_rvalid === 1'b1 && exp_q.size() > 0) begin
			qe = exp_q.pop_front();
			qm = msk_q.pop_front();
			`CHK(o_reg_rdata & qm, qe)
		end
	end
	// =====
	// Main sequence
	initial begin
		void'($urandom(23554));
		repeat (10) @(posedge i_mclk);
		#1;
		i_rst_n = 1'b1;
		`CHK({o_opmode, o_termselect, o_xcvrselect, o_tx_enable_n}, 6'h0f)
		`CHK({o_line_port_low_pd_en, o_line_port_high_pd_en, o_otg_ctl}, 10'h300)
		rd(8'h0c, 32'h7);
		rd(8'h18, 32'h52);
		rd(8'h1c, 32'h0, 32'h47);
		rd(8'h44, 32'h0);
		rd(8'h40, 32'h0);
		// Random control words, the last one zero for normal operation
		for (int i = 0; i < 4; i++) begin
			r = (i == 3) ? 32'h0 : $urandom();
			wr(8'h0c, r);
			`CHK({o_opmode, o_termselect, o_xcvrselect}, r[4:0])
			wr(8'h10, r);
			`CHK(o_otg_ctl, r[7:0] & 8'hdf)
			otg_in = r[5:0];
			rd(8'h0c, r & 32'h1f);
			rd(8'h10, r & 32'hdf);
			rd(8'h14, {26'h0, r[5:0]});
		end
		// Serial drive loops back through the model's receivers
		wr(8'h18, 32'h0d);
		`CHK({o_tx_se0, o_tx_dat, o_tx_enable_n, o_fsls_serial}, 4'hd)
		repeat (3) step();
		rd(8'h18, 32'h0d);
		wr(8'h18, 32'h04);
		repeat (3) step();
		rd(8'h18, 32'h54);
		wr(8'h18, 32'h02);
		// Line flags behind a 4-cycle filter
		wr(8'h40, 32'h200);
		pulse(i_pkt_start);
		host_ls = 2'h2;
		waitls(2'h2, 4);
		rd(8'h1c, 32'h10, 32'h10);
		host_ls = 2'h1;
		waitls(2'h1, 4);
		rd(8'h1c, 32'h18, 32'h18);
		pulse(i_pkt_start);
		rd(8'h1c, 32'h08, 32'h18);
		// Wake reporting for K, clear by zero, then SE0
		wr(8'h40, 32'h280);
		host_ls = 2'h2;
		waitls(2'h2, 4);
		pulse(i_auto_resume);
		rd(8'h40, 32'h1280, 32'h3f80);
		wr(8'h40, 32'h280);
		rd(8'h40, 32'h280, 32'h3f80);
		host_ls = 2'h0;
		waitls(2'h0, 4);
		pulse(i_auto_resume);
		rd(8'h40, 32'h2280, 32'h3f80);
		host_ls = 2'h1;
		wr(8'h40, 32'h40070);
		`CHK({o_line_port_low_pd_en, o_line_port_high_pd_en, o_transceiver_config_inputs}, 5'h07)
		rd(8'h40, 32'h40070);
		// Tokens: marked, unmarked, wrong address, read-only capture, frame
		dadr = 7'($urandom()) | 7'h01;
		wr(8'h08, {25'h0, dadr});
		rd(8'h08, {25'h0, dadr});
		wr(8'h34, 32'h0008);
		tok(dadr, 4'h9, 4'h3, 11'h0);
		`CHK({o_tok_fwd, o_rx_ep}, 6'h33)
		rd(8'h1c, 32'h40, 32'h40);
		rd(8'h2c, 32'h9);
		rd(8'h30, 32'h13);
		tok(dadr, 4'h1, 4'h2, 11'h0);
		`CHK({o_tok_fwd, o_rx_ep}, 6'h22)
		tok(dadr ^ 7'h40, 4'hd, 4'h5, 11'h0);
		`CHK(o_tok_fwd, 1'b0)
		wr(8'h2c, 32'hf);
		rd(8'h2c, 32'h1);
		r = $urandom();
		tok(dadr, 4'h5, 4'h0, r[10:0]);
		`CHK(o_tok_fwd, 1'b0)
		rd(8'h28, r & 32'h7ff);
		wr(8'h28, 32'hffffffff);
		rd(8'h28, 32'h7ff);
		// CRC16 flag through lanes b and d, cleared, then held
		wr(8'h24, 32'h04000400);
		pulse(i_pkt_start);
		`CHK(evp, 4'h0)
		pulse(i_crc16_fail);
		repeat (2) step();
		`CHK(evp, 4'ha)
		pulse(i_pkt_start);
		repeat (2) step();
		`CHK(evp, 4'h0)
		wr(8'h20, 32'h04);
		pulse(i_crc16_fail);
		pulse(i_pkt_start);
		repeat (2) step();
		`CHK(evp, 4'ha)
		wr(8'h1c, 32'h04);
		repeat (2) step();
		`CHK(evp, 4'h0)
		rx_in = 2'h2;
		repeat (3) step();
		rd(8'h1c, 32'h02, 32'h03);
		rx_in = 2'h1;
		repeat (3) step();
		rd(8'h1c, 32'h01, 32'h03);
		wr(8'h3c, 32'hffffffa5);
		`CHK(o_power_sig, 9'h1a5)
		rd(8'h3c, 32'h1a5);
		// Soft reset clears manager state but spares transceiver controls
		wr(8'h00, $urandom());
		`CHK(o_power_sig, 9'h000)
		rd(8'h08, 32'h0);
		rd(8'h34, 32'h0);
		rd(8'h40, 32'h40070);
		repeat (2) step();
		test_done();
	end
endmodule // uimr_regs_tb

/* File: uimr_xcvr_model.sv */
// Behavioural transceiver model that feeds line, receive and OTG levels to the manager.
module uimr_xcvr_model (
	input wire logic i_mclk,
	input wire logic i_tx_enable_n,
	input wire logic i_tx_se0,
	input wire logic i_tx_dat,
	input wire logic [1:0] i_host_ls,
	input wire logic [1:0] i_rx_in,
	input wire logic [5:0] i_otg_in,
	output logic [1:0] o_linestate,
	output logic o_rx_active,
	output logic o_rx_error,
	output logic o_rx_rcv,
	output logic o_rx_dm,
	output logic o_rx_dp,
	output logic [5:0] o_otg_status
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] ls;
	// =====
	// Line: our own serial drive wins while enabled, else the host's symbol shows
	always_comb begin
		if (!i_tx_enable_n) ls = i_tx_se0 ? 2'h0 : (i_tx_dat ? 2'h1 : 2'h2);
		else ls = i_host_ls;
	end
	// Levels move just after the edge, as from a receiver register stage
	always @(posedge i_mclk) begin
		#1;
		o_linestate = ls;
		o_rx_dp = ls[0];
		o_rx_dm = ls[1];
		o_rx_rcv = ls[0];
		{o_rx_active, o_rx_error} = i_rx_in;
		o_otg_status = i_otg_in;
	end
	// Idle bus shows J so the first reads see settled levels
	initial begin
		o_linestate = 2'h1;
		{o_rx_active, o_rx_error, o_rx_dm} = 3'h0;
		{o_rx_rcv, o_rx_dp} = 2'h3;
		o_otg_status = 6'h00;
	end
endmodule // uimr_xcvr_model
